/* File: mov_exec_pkg.sv */
// Purpose: shared constants for the data-move instruction executor
// Assumes: 8-bit data, 12-bit data space, four quarter-phases per cycle
// Notes:   register offsets are byte addresses on the AXI4-Lite slave
package mov_exec_pkg;

    localparam int          DATA_W          = 8;
    localparam int          DADDR_W         = 12;
    localparam int          WORD_W          = 16;
    localparam int          AXI_ADDR_W      = 8;

    // opcode fields
    localparam logic [5:0]  OPC_REG_COPY    = 6'h14;
    localparam logic [3:0]  OPC_MM_SRC      = 4'hc;
    localparam logic [3:0]  OPC_MM_DST      = 4'hf;
    localparam int          DEST_BIT        = 9;
    localparam int          ACCESS_BIT      = 8;

    // access bank split and indexed range
    localparam logic [7:0]  INDEXED_MAX     = 8'h5f;
    localparam logic [3:0]  ACCESS_LOW_PAGE = 4'h0;
    localparam logic [3:0]  ACCESS_HI_PAGE  = 4'hf;

    // accumulator location in the data space
    localparam logic [11:0] ACC_ADDR_DEF    = 12'hff8;

    // quarter phases
    localparam logic [1:0]  Q1              = 2'h0;
    localparam logic [1:0]  Q2              = 2'h1;
    localparam logic [1:0]  Q3              = 2'h2;
    localparam logic [1:0]  Q4              = 2'h3;

    // register offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_BANK        = 8'h04;
    localparam logic [7:0]  OFS_INDEX       = 8'h08;
    localparam logic [7:0]  OFS_ACC         = 8'h0c;
    localparam logic [7:0]  OFS_STATUS      = 8'h10;
    localparam logic [7:0]  OFS_COUNT       = 8'h14;

    // field positions
    localparam int          CTRL_EXT_BIT    = 0;
    localparam int          STAT_Z_BIT      = 0;
    localparam int          STAT_N_BIT      = 1;
    localparam int          STAT_BUSY_BIT   = 2;

    // reset values
    localparam logic        EXT_RST         = 1'b0;
    localparam logic [3:0]  BANK_RST        = 4'h0;
    localparam logic [11:0] INDEX_RST       = 12'h000;
    localparam logic [7:0]  ACC_RST         = 8'h00;
    localparam logic [15:0] COUNT_RST       = 16'h0000;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

/* File: quarter_phase_gen.sv */
// Purpose: quarter-phase counter, Q1..Q4 on successive clocks
// Assumes: synchronous active-high reset
// Notes:   restarts at Q1 after reset
`timescale 1ns/1ps
`default_nettype none
module quarter_phase_gen (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    output logic      [1:0] q_o
);
    import mov_exec_pkg::*;

    logic [1:0] q_reg;
    logic [1:0] q_next;

    always_comb begin
        q_next = q_reg + 2'h1;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            q_reg <= Q1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q_o = q_reg;
endmodule
`default_nettype wire

/* File: data_addr_form.sv */
// Purpose: forms the 12-bit data address of a register-copy operand
// Assumes: bank select holds only its low nibble
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module data_addr_form (
    input  wire logic [7:0]  f_i,
    input  wire logic        access_sel_i,
    input  wire logic        ext_en_i,
    input  wire logic [3:0]  bank_i,
    input  wire logic [11:0] index_base_i,
    output logic      [11:0] addr_o
);
    import mov_exec_pkg::*;

    always_comb begin
        if (access_sel_i) begin
            addr_o = {bank_i, f_i};
        end else if (ext_en_i && (f_i <= INDEXED_MAX)) begin
            addr_o = index_base_i + {4'h0, f_i};
        end else if (f_i <= INDEXED_MAX) begin
            addr_o = {ACCESS_LOW_PAGE, f_i};
        end else begin
            addr_o = {ACCESS_HI_PAGE, f_i};
        end
    end
endmodule
`default_nettype wire

/* File: register_move_instruction_exec.sv */
// Purpose: executes the register-copy and memory-to-memory copy instructions
// Assumes: fetch stage and data memory share mclk_i; memory read data one clock late
// Notes:   one instruction cycle is four clocks, Q1..Q4
//
// Overview of operation
// - opcode 0101 00da ffff ffff copies a register, updating negative and zero
// - destination bit 0 writes accumulator, 1 writes back to the source register
// - access bit 0 uses access bank, 1 uses bank select plus register field
// - access bit 0, extended set on, field up to 5Fh: indexed offset addressing
// - memory copy moves any byte 000h..FFFh unchanged, flags untouched
// - memory copy is two words: 1100 plus source, 1111 plus destination
// - accumulator may be source or destination of the memory copy
// - memory copy first cycle: decode, read source in Q2, idle Q4
// - memory copy second cycle: no dummy read, destination write in Q4
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module register_move_instruction_exec #(
    parameter logic [11:0] ACC_ADDR = mov_exec_pkg::ACC_ADDR_DEF
) (
    input  wire logic                               mclk_i,
    input  wire logic                               rst_i,
    input  wire logic [mov_exec_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic                               s_axi_awvalid_i,
    output logic                                    s_axi_awready_o,
    input  wire logic [31:0]                        s_axi_wdata_i,
    input  wire logic [3:0]                         s_axi_wstrb_i,
    input  wire logic                               s_axi_wvalid_i,
    output logic                                    s_axi_wready_o,
    output logic      [1:0]                         s_axi_bresp_o,
    output logic                                    s_axi_bvalid_o,
    input  wire logic                               s_axi_bready_i,
    input  wire logic [mov_exec_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic                               s_axi_arvalid_i,
    output logic                                    s_axi_arready_o,
    output logic      [31:0]                        s_axi_rdata_o,
    output logic      [1:0]                         s_axi_rresp_o,
    output logic                                    s_axi_rvalid_o,
    input  wire logic                               s_axi_rready_i,
    input  wire logic [mov_exec_pkg::WORD_W-1:0]    instr_word_i,
    input  wire logic                               instr_valid_i,
    output logic                                    instr_ready_o,
    output logic      [mov_exec_pkg::DADDR_W-1:0]   mem_addr_o,
    output logic                                    mem_rd_o,
    input  wire logic [mov_exec_pkg::DATA_W-1:0]    mem_rdata_i,
    output logic                                    mem_wr_o,
    output logic      [mov_exec_pkg::DATA_W-1:0]    mem_wdata_o
);
    import mov_exec_pkg::*;

    typedef enum logic [2:0] {S_DECODE, S_COPY, S_MM_SRC, S_MM_WAIT, S_MM_DST} exec_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [1:0]         q;
    exec_state_e        state_reg;
    exec_state_e        state_next;
    logic [15:0]        word_reg;
    logic [15:0]        word_next;
    logic [11:0]        addr_reg;
    logic [11:0]        addr_next;
    logic [7:0]         data_reg;
    logic [7:0]         data_next;
    logic [7:0]         acc_reg;
    logic [7:0]         acc_next;
    logic               flag_n_reg;
    logic               flag_n_next;
    logic               flag_z_reg;
    logic               flag_z_next;
    logic [15:0]        count_reg;
    logic [15:0]        count_next;
    logic               ext_en_reg;
    logic               ext_en_next;
    logic [3:0]         bank_reg;
    logic [3:0]         bank_next;
    logic [11:0]        index_reg;
    logic [11:0]        index_next;
    logic [11:0]        copy_addr;
    logic [7:0]         src_val;
    logic               take;
    logic               is_copy;
    logic               is_mm_src;
    logic               src_is_acc;

    logic               aw_hold_reg;
    logic               aw_hold_next;
    logic [7:0]         aw_addr_reg;
    logic [7:0]         aw_addr_next;
    logic               w_hold_reg;
    logic               w_hold_next;
    logic [31:0]        w_data_reg;
    logic [31:0]        w_data_next;
    logic [3:0]         w_strb_reg;
    logic [3:0]         w_strb_next;
    logic               bvalid_reg;
    logic               bvalid_next;
    logic [1:0]         bresp_reg;
    logic [1:0]         bresp_next;
    logic               rvalid_reg;
    logic               rvalid_next;
    logic [31:0]        rdata_reg;
    logic [31:0]        rdata_next;
    logic [1:0]         rresp_reg;
    logic [1:0]         rresp_next;
    logic               do_write;
    logic [31:0]        rd_word;
    logic               rd_hit;

    ////////////////////////////////////////////////////////////////////////////////
    // submodules

    quarter_phase_gen u_qgen (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .q_o    (q)
    );

    data_addr_form u_addr (
        .f_i          (instr_word_i[7:0]),
        .access_sel_i (instr_word_i[ACCESS_BIT]),
        .ext_en_i     (ext_en_reg),
        .bank_i       (bank_reg),
        .index_base_i (index_reg),
        .addr_o       (copy_addr)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // instruction execution

    assign instr_ready_o = (q == Q1) && ((state_reg == S_DECODE) || (state_reg == S_MM_WAIT));
    assign take          = instr_ready_o && instr_valid_i;
    assign is_copy       = (instr_word_i[15:10] == OPC_REG_COPY);
    assign is_mm_src     = (instr_word_i[15:12] == OPC_MM_SRC);
    assign src_is_acc    = (addr_reg == ACC_ADDR);
    assign src_val       = src_is_acc ? acc_reg : mem_rdata_i;

    assign mem_rd_o = (q == Q2) && !src_is_acc
                      && ((state_reg == S_COPY) || (state_reg == S_MM_SRC));
    assign mem_wr_o = (q == Q4) && !src_is_acc
                      && (((state_reg == S_COPY) && word_reg[DEST_BIT])
                          || (state_reg == S_MM_DST));
    assign mem_addr_o  = addr_reg;
    assign mem_wdata_o = data_reg;

    always_comb begin
        state_next  = state_reg;
        word_next   = word_reg;
        addr_next   = addr_reg;
        data_next   = data_reg;
        acc_next    = acc_reg;
        flag_n_next = flag_n_reg;
        flag_z_next = flag_z_reg;
        count_next  = count_reg;
        if (do_write && (aw_addr_reg == OFS_ACC) && w_strb_reg[0]) begin
            acc_next = w_data_reg[7:0];
        end
        case (state_reg)
            S_DECODE: begin
                if (take) begin
                    word_next = instr_word_i;
                    if (is_copy) begin
                        addr_next  = copy_addr;
                        state_next = S_COPY;
                    end else if (is_mm_src) begin
                        addr_next  = instr_word_i[11:0];
                        state_next = S_MM_SRC;
                    end
                end
            end
            S_COPY: begin
                if (q == Q3) begin
                    data_next   = src_val;
                    flag_z_next = (src_val == 8'h00);
                    flag_n_next = src_val[7];
                end
                if (q == Q4) begin
                    if (!word_reg[DEST_BIT] || src_is_acc) begin
                        acc_next = data_reg;
                    end
                    count_next = count_reg + 16'h0001;
                    state_next = S_DECODE;
                end
            end
            S_MM_SRC: begin
                if (q == Q3) begin
                    data_next = src_val;
                end
                if (q == Q4) begin
                    state_next = S_MM_WAIT;
                end
            end
            S_MM_WAIT: begin
                if (take) begin
                    word_next = instr_word_i;
                    if (instr_word_i[15:12] == OPC_MM_DST) begin
                        addr_next  = instr_word_i[11:0];
                        state_next = S_MM_DST;
                    end else begin
                        state_next = S_DECODE;
                    end
                end
            end
            S_MM_DST: begin
                if (q == Q4) begin
                    if (src_is_acc) begin
                        acc_next = data_reg;
                    end
                    count_next = count_reg + 16'h0001;
                    state_next = S_DECODE;
                end
            end
            default: begin
                state_next = S_DECODE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state_reg  <= S_DECODE;
            word_reg   <= 16'h0000;
            addr_reg   <= 12'h000;
            data_reg   <= 8'h00;
            acc_reg    <= ACC_RST;
            flag_n_reg <= 1'b0;
            flag_z_reg <= 1'b0;
            count_reg  <= COUNT_RST;
        end else begin
            state_reg  <= state_next;
            word_reg   <= word_next;
            addr_reg   <= addr_next;
            data_reg   <= data_next;
            acc_reg    <= acc_next;
            flag_n_reg <= flag_n_next;
            flag_z_reg <= flag_z_next;
            count_reg  <= count_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_comb begin
        ext_en_next = ext_en_reg;
        bank_next   = bank_reg;
        index_next  = index_reg;
        if (do_write) begin
            if ((aw_addr_reg == OFS_CTRL) && w_strb_reg[0]) begin
                ext_en_next = w_data_reg[CTRL_EXT_BIT];
            end
            if ((aw_addr_reg == OFS_BANK) && w_strb_reg[0]) begin
                bank_next = w_data_reg[3:0];
            end
            if ((aw_addr_reg == OFS_INDEX) && w_strb_reg[0]) begin
                index_next[7:0] = w_data_reg[7:0];
            end
            if ((aw_addr_reg == OFS_INDEX) && w_strb_reg[1]) begin
                index_next[11:8] = w_data_reg[11:8];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ext_en_reg <= EXT_RST;
            bank_reg   <= BANK_RST;
            index_reg  <= INDEX_RST;
        end else begin
            ext_en_reg <= ext_en_next;
            bank_reg   <= bank_next;
            index_reg  <= index_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    assign s_axi_awready_o = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready_o  = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rdata_o   = rdata_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign do_write        = aw_hold_reg && w_hold_reg;

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr_i)
            OFS_CTRL:   rd_word[CTRL_EXT_BIT] = ext_en_reg;
            OFS_BANK:   rd_word[3:0] = bank_reg;
            OFS_INDEX:  rd_word[11:0] = index_reg;
            OFS_ACC:    rd_word[7:0] = acc_reg;
            OFS_STATUS: begin
                rd_word[STAT_Z_BIT]    = flag_z_reg;
                rd_word[STAT_N_BIT]    = flag_n_reg;
                rd_word[STAT_BUSY_BIT] = (state_reg != S_DECODE);
            end
            OFS_COUNT:  rd_word[15:0] = count_reg;
            default:    rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rdata_next   = rdata_reg;
        rresp_next   = rresp_reg;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_next = 1'b1;
            w_data_next = s_axi_wdata_i;
            w_strb_next = s_axi_wstrb_i;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (aw_addr_reg <= OFS_COUNT) && (aw_addr_reg[1:0] == 2'h0)
                           ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            rvalid_next = 1'b1;
            rdata_next  = rd_word;
            rresp_next  = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready_i) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            aw_hold_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_hold_reg  <= 1'b0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= RESP_OKAY;
        end else begin
            aw_hold_reg <= aw_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_hold_reg  <= w_hold_next;
            w_data_reg  <= w_data_next;
            w_strb_reg  <= w_strb_next;
            bvalid_reg  <= bvalid_next;
            bresp_reg   <= bresp_next;
            rvalid_reg  <= rvalid_next;
            rdata_reg   <= rdata_next;
            rresp_reg   <= rresp_next;
        end
    end
endmodule
`default_nettype wire

/* File: reg_move_chk.sv */
// Purpose: port checker for the data-move executor
// Assumes: sees only the top module ports
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module reg_move_chk
    import mov_exec_pkg::*;
#(
    parameter logic [11:0] ACC_ADDR = mov_exec_pkg::ACC_ADDR_DEF
) (
    input wire logic                             mclk_i,
    input wire logic                             rst_i,
    input wire logic [mov_exec_pkg::WORD_W-1:0]  instr_word_i,
    input wire logic                             instr_valid_i,
    input wire logic                             instr_ready_o,
    input wire logic [mov_exec_pkg::DADDR_W-1:0] mem_addr_o,
    input wire logic                             mem_rd_o,
    input wire logic [mov_exec_pkg::DATA_W-1:0]  mem_rdata_i,
    input wire logic                             mem_wr_o,
    input wire logic [mov_exec_pkg::DATA_W-1:0]  mem_wdata_o,
    input wire logic                             s_axi_bvalid_o,
    input wire logic                             s_axi_bready_i,
    input wire logic [1:0]                       s_axi_bresp_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic tk;
    assign tk = instr_valid_i && instr_ready_o;
    ////////////////////////////////////////////////////////////////////////
    sequence mm_src_s;
        tk && instr_word_i[15:12] == OPC_MM_SRC && instr_word_i[11:0] != ACC_ADDR;
    endsequence
    sequence mm_dst_s;
        tk && instr_word_i[15:12] == OPC_MM_DST && instr_word_i[11:0] != ACC_ADDR;
    endsequence
    sequence rc_hi_s;
        tk && instr_word_i[15:10] == OPC_REG_COPY && !instr_word_i[ACCESS_BIT]
            && instr_word_i[7:0] inside {[8'h60:8'hf7]};
    endsequence
    ////////////////////////////////////////////////////////////////////////
    strobe_excl_a: assert property (!(mem_rd_o && mem_wr_o))
        else $error("read and write strobes together");
    rd_to_ready_a: assert property (mem_rd_o |-> ##3 instr_ready_o)
        else $error("no new cycle three clocks after read");
    rc_read_a: assert property (rc_hi_s |=> mem_rd_o
        && mem_addr_o == {4'hf, $past(instr_word_i[7:0])})
        else $error("register copy read wrong");
    rc_dest_a: assert property (rc_hi_s |-> ##3 mem_wr_o == $past(instr_word_i[9], 3)
        && (!mem_wr_o || mem_wdata_o == $past(mem_rdata_i)))
        else $error("register copy destination wrong");
    mm_read_a: assert property (mm_src_s |=> mem_rd_o
        && mem_addr_o == $past(instr_word_i[11:0]))
        else $error("memory copy source read wrong");
    mm_no_dummy_a: assert property (mm_dst_s |=> !mem_rd_o [*3])
        else $error("read in second copy cycle");
    mm_write_a: assert property (mm_src_s ##4 mm_dst_s |=> !mem_wr_o ##1 !mem_wr_o
        ##1 mem_wr_o && mem_addr_o == $past(instr_word_i[11:0], 3)
        && mem_wdata_o == $past(mem_rdata_i, 5))
        else $error("memory copy write wrong");
    b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped");
endmodule
bind register_move_instruction_exec reg_move_chk #(.ACC_ADDR(ACC_ADDR)) u_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .instr_word_i(instr_word_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o));
`default_nettype wire

/* File: data_mem_model.sv */
// Purpose: data memory on the far side of the executor
// Assumes: read data valid the clock after the read strobe
// Notes:   outside that clock the data lines toggle
`timescale 1ns/1ps
`default_nettype none
module data_mem_model
    import mov_exec_pkg::*;
(
    input  wire logic                             mclk_i,
    input  wire logic [mov_exec_pkg::DADDR_W-1:0] addr_i,
    input  wire logic                             rd_i,
    input  wire logic                             wr_i,
    input  wire logic [mov_exec_pkg::DATA_W-1:0]  wdata_i,
    output logic      [mov_exec_pkg::DATA_W-1:0]  rdata_o
);
    logic [DATA_W-1:0] mem [0:4095];
    initial rdata_o = 8'h00;
    always @(posedge mclk_i) begin
        if (rd_i) rdata_o <= mem[addr_i];
        else rdata_o <= ~rdata_o;
        if (wr_i) mem[addr_i] <= wdata_i;
    end
endmodule
`default_nettype wire

/* File: register_move_instruction_exec_tb_top.sv */
// Purpose: bench for the data-move executor
// Assumes: 20 MHz clock, AXI4-Lite register access
// Notes:   fetch stage played by the issue task
`timescale 1ns/1ps
`default_nettype none
module register_move_instruction_exec_tb_top;
    import mov_exec_pkg::*;
    logic        mclk_i = 0;
    logic        rst_i = 1;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, iv = 0;
    logic        awready, wready, bvalid, arready, rvalid, ir, mrd, mwr;
    logic [1:0]  bresp, rresp;
    logic [15:0] iw = 0;
    logic [11:0] ma;
    logic [7:0]  mrdat, mwd;
    logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_BANK, OFS_INDEX, OFS_ACC, OFS_STATUS, OFS_COUNT};
    int          err_total = 0, check_count = 0, cyc = 0;
    always #25 mclk_i = ~mclk_i;
    ////////////////////////////////////////////////////////////////////////
    register_move_instruction_exec u_register_move_instruction_exec (
        .mclk_i(mclk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .instr_word_i(iw), .instr_valid_i(iv),
        .instr_ready_o(ir), .mem_addr_o(ma), .mem_rd_o(mrd), .mem_rdata_i(mrdat),
        .mem_wr_o(mwr), .mem_wdata_o(mwd));
    data_mem_model u_mem (.mclk_i(mclk_i), .addr_i(ma), .rd_i(mrd), .wr_i(mwr),
        .wdata_i(mwd), .rdata_o(mrdat));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            test_done;
        end
    end
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        logic [1:0] r;
        @(posedge mclk_i);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge mclk_i);
            aw = awready && awvalid;
            w = wready && wvalid;
            @(posedge mclk_i);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
        end while (awvalid && !aw || wvalid && !w);
        do @(negedge mclk_i); while (!bvalid);
        r = bresp;
        @(posedge mclk_i);
        bready <= 0;
        chk(r, er);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge mclk_i);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(negedge mclk_i); while (!arready);
        @(posedge mclk_i);
        arvalid <= 0;
        do @(negedge mclk_i); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge mclk_i);
        rready <= 0;
        chk(d, ed);
        chk(r, er);
    endtask
    task automatic issue(input logic [15:0] w, input int n);
        @(posedge mclk_i);
        iw <= w;
        iv <= 1;
        do @(negedge mclk_i); while (!ir);
        @(posedge mclk_i);
        iv <= 0;
        repeat (n) @(posedge mclk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        u_mem.mem[12'hf80] = 8'h80;
        u_mem.mem[12'h322] = 8'h00;
        u_mem.mem[12'h010] = 8'h7f;
        u_mem.mem[12'h210] = 8'h81;
        u_mem.mem[12'h123] = 8'h5c;
        u_mem.mem[12'h000] = 8'ha5;
        repeat (20) @(posedge mclk_i);
        rst_i <= 0;
        axw(OFS_STATUS, 32'h7, RESP_OKAY);
        axw(OFS_COUNT, 32'h9, RESP_OKAY);
        foreach (ofs[i]) axr(ofs[i], 32'h0, RESP_OKAY);
        axr(8'h18, 32'h0, RESP_SLVERR);
        axw(8'h02, 32'h1, RESP_SLVERR);
        axw(OFS_BANK, 32'h3, RESP_OKAY);
        axw(OFS_INDEX, 32'h200, RESP_OKAY);
        issue(16'h5080, 4);
        axr(OFS_ACC, 32'h80, RESP_OKAY);
        axr(OFS_STATUS, 32'h2, RESP_OKAY);
        issue(16'h5122, 4);
        axr(OFS_STATUS, 32'h1, RESP_OKAY);
        issue(16'h5010, 4);
        axr(OFS_ACC, 32'h7f, RESP_OKAY);
        axw(OFS_CTRL, 32'h1, RESP_OKAY);
        issue(16'h5210, 4);
        axr(OFS_STATUS, 32'h2, RESP_OKAY);
        axr(OFS_ACC, 32'h7f, RESP_OKAY);
        chk(u_mem.mem[12'h210], 32'h81);
        issue(16'h52f8, 4);
        axr(OFS_STATUS, 32'h0, RESP_OKAY);
        axr(OFS_ACC, 32'h7f, RESP_OKAY);
        // dest away from program counter and stack top bytes
        issue(16'hc123, 0);
        issue(16'hf456, 4);
        chk(u_mem.mem[12'h456], 32'h5c);
        issue(16'hc000, 0);
        issue(16'hfff8, 4);
        axr(OFS_ACC, 32'ha5, RESP_OKAY);
        issue(16'hcff8, 0);
        issue(16'hffff, 4);
        chk(u_mem.mem[12'hfff], 32'ha5);
        axr(OFS_STATUS, 32'h0, RESP_OKAY);
        axr(OFS_COUNT, 32'h8, RESP_OKAY);
        test_done;
    end
endmodule
`default_nettype wire
